// file: core/low_speed_countdown_timer.sv
`timescale 1ns/1ns
module low_speed_countdown_timer
   import lsc_timer_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic lsclk_in,
   input wire logic low_power_in,
   input wire logic timer_control_wr_in,
   input wire logic [WORD_W-1:0] timer_control_data_in,
   input wire logic first_reload_wr_in,
   input wire logic second_reload_wr_in,
   input wire logic [CNT_W-1:0] reload_data_in,
   input wire logic [PAT_WORDS-1:0] pattern_wr_in,
   input wire logic [WORD_W-1:0] pattern_data_in,
   input wire logic [IRQ_W-1:0] irq_mask_reg_in,
   input wire logic countdown_irq_clear_in,
   input wire logic calendar_irq_in,
   output logic [WORD_W-1:0] timer_control_out,
   output logic timer_run_enable_out,
   output logic [CNT_W-1:0] count_out,
   output logic [CNT_W-1:0] first_reload_value_out,
   output logic [CNT_W-1:0] second_reload_value_out,
   output logic [PAT_W-1:0] pattern_out,
   output logic [PAT_IDX_W-1:0] pattern_index_out,
   output logic [IRQ_W-1:0] raw_irq_status_out,
   output logic [IRQ_W-1:0] masked_irq_status_out,
   output logic combined_irq_out
);
   logic tick;
   logic ctrl_pend_reg;
   logic [WORD_W-1:0] ctrl_pend_data_reg;
   logic [WORD_W-1:0] ctrl_reg;
   logic run_reg;
   logic run_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] reload1_reg;
   logic [CNT_W-1:0] reload2_reg;
   logic [PAT_W-1:0] pattern_reg;
   logic [PAT_IDX_W-1:0] idx_reg;
   logic countdown_irq_reg;
   logic calendar_irq_reg;
   logic oneshot_select;
   logic self_start;
   logic [PAT_IDX_W-1:0] pattern_len;
   logic at_zero;
   logic fire;
   logic start_evt;
   logic reload_wr;
   logic [IRQ_W-1:0] raw_irq;

   ls_tick_detect u_tick (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .lsclk_in(lsclk_in),
      .low_power_in(low_power_in),
      .tick_out(tick)
   );

   assign oneshot_select = ctrl_reg[CTRL_ONESHOT_BIT];
   assign self_start = ctrl_reg[CTRL_SELFSTART_BIT];
   assign pattern_len = ctrl_reg[CTRL_PLEN_MSB:CTRL_PLEN_LSB];
   assign at_zero = (count_reg == COUNT_ZERO);
   assign fire = tick & run_reg & at_zero;
   assign reload_wr = first_reload_wr_in | second_reload_wr_in;
   assign start_evt = run_next & ~run_reg;

   // Control writes land on the next slow tick, so read-back lags by up to one slow period
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_pend_reg <= 1'b0;
         ctrl_pend_data_reg <= CTRL_RESET;
      end else if (timer_control_wr_in) begin
         ctrl_pend_reg <= 1'b1;
         ctrl_pend_data_reg <= timer_control_data_in & CTRL_USED_MASK;
      end else if (tick) begin
         ctrl_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_reg <= CTRL_RESET;
      end else if (tick && ctrl_pend_reg) begin
         ctrl_reg <= ctrl_pend_data_reg;
      end
   end

   // Software starting the timer wins over the hardware halt in the same cycle
   always_comb begin
      run_next = run_reg;
      if (fire && oneshot_select) begin
         run_next = 1'b0;
      end
      if (!run_reg && reload_wr && self_start) begin
         run_next = 1'b1;
      end
      if (!run_reg && first_reload_wr_in && oneshot_select) begin
         run_next = 1'b1;
      end
      if (tick && ctrl_pend_reg) begin
         run_next = ctrl_pend_data_reg[CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
      end
   end

   // Reload registers only take writes while halted
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reload1_reg <= RELOAD_RESET;
      end else if (first_reload_wr_in && !run_reg) begin
         reload1_reg <= reload_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reload2_reg <= RELOAD_RESET;
      end else if (second_reload_wr_in && !run_reg) begin
         reload2_reg <= reload_data_in;
      end
   end

   genvar w;
   generate
      for (w = 0; w < PAT_WORDS; w++) begin : g_pat
         always_ff @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
               pattern_reg[w*WORD_W +: WORD_W] <= PATTERN_RESET[w*WORD_W +: WORD_W];
            end else if (pattern_wr_in[w]) begin
               pattern_reg[w*WORD_W +: WORD_W] <= pattern_data_in;
            end
         end
      end
   endgenerate

   // A start loads from the first reload value; a first reload value written in the start cycle is taken directly
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_reg <= COUNT_RESET;
      end else if (start_evt) begin
         count_reg <= first_reload_wr_in ? reload_data_in : reload1_reg;
      end else if (fire && !oneshot_select) begin
         if (pattern_reg[idx_reg]) begin
            count_reg <= reload2_reg;
         end else begin
            count_reg <= reload1_reg;
         end
      end else if (tick && run_reg && !at_zero) begin
         count_reg <= count_reg - COUNT_STEP;
      end
   end

   // Pattern position wraps after the programmed number of bits; zero length keeps bit 0
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idx_reg <= IDX_ZERO;
      end else if (start_evt) begin
         idx_reg <= IDX_ZERO;
      end else if (fire && !oneshot_select) begin
         if (idx_reg + IDX_STEP >= pattern_len) begin
            idx_reg <= IDX_ZERO;
         end else begin
            idx_reg <= idx_reg + IDX_STEP;
         end
      end
   end

   // A new zero event in the clear cycle keeps the flag set
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         countdown_irq_reg <= 1'b0;
      end else begin
         countdown_irq_reg <= fire | (countdown_irq_reg & ~countdown_irq_clear_in);
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         calendar_irq_reg <= 1'b0;
      end else begin
         calendar_irq_reg <= calendar_irq_in;
      end
   end

   assign raw_irq = {calendar_irq_reg, countdown_irq_reg};

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         raw_irq_status_out <= IRQ_NONE;
         masked_irq_status_out <= IRQ_NONE;
         combined_irq_out <= 1'b0;
      end else begin
         raw_irq_status_out <= raw_irq;
         masked_irq_status_out <= raw_irq & irq_mask_reg_in;
         combined_irq_out <= |(raw_irq & irq_mask_reg_in);
      end
   end

   // Control read-back shows live run state in the run bit
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         timer_control_out <= CTRL_RESET;
         timer_run_enable_out <= 1'b0;
         count_out <= COUNT_RESET;
         first_reload_value_out <= RELOAD_RESET;
         second_reload_value_out <= RELOAD_RESET;
         pattern_out <= PATTERN_RESET;
         pattern_index_out <= IDX_ZERO;
      end else begin
         timer_control_out <= ctrl_reg;
         timer_control_out[CTRL_RUN_BIT] <= run_reg;
         timer_run_enable_out <= run_reg;
         count_out <= count_reg;
         first_reload_value_out <= reload1_reg;
         second_reload_value_out <= reload2_reg;
         pattern_out <= pattern_reg;
         pattern_index_out <= idx_reg;
      end
   end
endmodule

// file: core/lsc_timer_pkg.sv
package lsc_timer_pkg;
   localparam int CNT_W = 32;
   localparam int PAT_W = 128;
   localparam int PAT_WORDS = 4;
   localparam int WORD_W = 32;
   localparam int PAT_IDX_W = 7;
   localparam int IRQ_W = 2;
   localparam int IRQ_CD = 0;
   localparam int IRQ_CAL = 1;

   // Timer control word layout
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_ONESHOT_BIT = 1;
   localparam int CTRL_SELFSTART_BIT = 2;
   localparam int CTRL_PLEN_LSB = 4;
   localparam int CTRL_PLEN_MSB = 10;

   localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [WORD_W-1:0] CTRL_USED_MASK = 32'h0000_07F7;
   localparam logic [CNT_W-1:0] COUNT_RESET = 32'hFFFF_FFFF;
   localparam logic [CNT_W-1:0] RELOAD_RESET = 32'h0000_0000;
   localparam logic [PAT_W-1:0] PATTERN_RESET = '0;
   localparam logic [CNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] COUNT_STEP = 32'h0000_0001;
   localparam logic [PAT_IDX_W-1:0] IDX_ZERO = 7'h00;
   localparam logic [PAT_IDX_W-1:0] IDX_STEP = 7'h01;
   localparam logic [IRQ_W-1:0] IRQ_NONE = 2'h0;

   // Low-speed clock figures, kept for reference only; neither the design nor the bench uses them
   localparam real LS_CLK_KHZ = 32.0;
   localparam real CTRL_WRITE_GAP_US = 140.0;
endpackage

// file: core/ls_tick_detect.sv
`timescale 1ns/1ns
module ls_tick_detect
   import lsc_timer_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic lsclk_in,
   input wire logic low_power_in,
   output logic tick_out
);
   logic lsclk_d_reg;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lsclk_d_reg <= 1'b0;
      end else begin
         lsclk_d_reg <= lsclk_in;
      end
   end

   // Ticks are masked while low_power_in is high, even with the low-speed clock running, so no tick can wake anything
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= lsclk_in & ~lsclk_d_reg & ~low_power_in;
      end
   end
endmodule

// file: bench/lsc_timer_props.sv
`timescale 1ns/1ns
module lsc_timer_props
   import lsc_timer_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic low_power_in,
   input wire logic first_reload_wr_in,
   input wire logic [IRQ_W-1:0] irq_mask_reg_in,
   input wire logic countdown_irq_clear_in,
   input wire logic [WORD_W-1:0] timer_control_out,
   input wire logic timer_run_enable_out,
   input wire logic [CNT_W-1:0] count_out,
   input wire logic [CNT_W-1:0] first_reload_value_out,
   input wire logic [IRQ_W-1:0] raw_irq_status_out,
   input wire logic [IRQ_W-1:0] masked_irq_status_out,
   input wire logic combined_irq_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_irq;
      $rose(raw_irq_status_out[IRQ_CD]);
   endsequence
   sequence s_busy_write;
      first_reload_wr_in && timer_run_enable_out ##1 timer_run_enable_out;
   endsequence
   property p_cause;
      s_irq |-> $past(timer_run_enable_out) && $past(count_out) == COUNT_ZERO;
   endproperty
   a_cause: assert property (p_cause) else $error("irq without zero count");
   property p_hold;
      raw_irq_status_out[IRQ_CD] && !$past(countdown_irq_clear_in)
         |=> raw_irq_status_out[IRQ_CD];
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped uncleared");
   property p_oneshot;
      s_irq ##0 timer_control_out[CTRL_ONESHOT_BIT] |-> count_out == COUNT_ZERO
         && !timer_run_enable_out;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot did not halt");
   property p_ignore;
      s_busy_write |=> $stable(first_reload_value_out);
   endproperty
   a_ignore: assert property (p_ignore) else $error("reload taken while running");
   property p_step;
      $past(timer_run_enable_out) && $past(count_out) != COUNT_ZERO && $changed(count_out)
         |-> count_out == $past(count_out) - COUNT_STEP;
   endproperty
   a_step: assert property (p_step) else $error("count step not one");
   property p_freeze;
      low_power_in [*6] |-> $stable(count_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("count moved in low power");
   property p_mask;
      masked_irq_status_out == (raw_irq_status_out & $past(irq_mask_reg_in));
   endproperty
   a_mask: assert property (p_mask) else $error("masked status wrong");
   property p_comb;
      combined_irq_out == |masked_irq_status_out;
   endproperty
   a_comb: assert property (p_comb) else $error("combined irq wrong");
endmodule

// file: bench/tb_low_speed_countdown_timer.sv
`timescale 1ns/1ns
module tb_low_speed_countdown_timer;
   import lsc_timer_pkg::*;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic lsclk_in = 1'b0;
   logic low_power_in = 1'b0;
   logic timer_control_wr_in = 1'b0;
   logic [WORD_W-1:0] timer_control_data_in = '0;
   logic first_reload_wr_in = 1'b0;
   logic second_reload_wr_in = 1'b0;
   logic [CNT_W-1:0] reload_data_in = '0;
   logic [PAT_WORDS-1:0] pattern_wr_in = '0;
   logic [WORD_W-1:0] pattern_data_in = '0;
   logic [IRQ_W-1:0] irq_mask_reg_in = '0;
   logic countdown_irq_clear_in = 1'b0;
   logic calendar_irq_in = 1'b0;
   logic [WORD_W-1:0] timer_control_out;
   logic timer_run_enable_out;
   logic [CNT_W-1:0] count_out, first_reload_value_out, second_reload_value_out;
   logic [PAT_W-1:0] pattern_out;
   logic [PAT_IDX_W-1:0] pattern_index_out;
   logic [IRQ_W-1:0] raw_irq_status_out, masked_irq_status_out;
   logic combined_irq_out;
   int miscompares = 0;
   int comparisons = 0;
   low_speed_countdown_timer dut (.*);
   always #4 clock_in = ~clock_in;
   // Slow clock sped up to 16 system cycles so whole periods fit the run
   always begin
      repeat (8) @(negedge clock_in);
      lsclk_in = ~lsclk_in;
   end
   task chk(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Spacing covers three slow periods so the commit is always visible
   task ctrl(input logic [WORD_W-1:0] d);
      timer_control_data_in = d;
      timer_control_wr_in = 1'b1;
      @(negedge clock_in);
      timer_control_wr_in = 1'b0;
      repeat (60) @(negedge clock_in);
      chk(timer_control_out & ~32'h0000_0001, d & CTRL_USED_MASK & ~32'h0000_0001);
   endtask
   task reload(input bit second, input logic [CNT_W-1:0] d);
      reload_data_in = d;
      first_reload_wr_in = !second;
      second_reload_wr_in = second;
      @(negedge clock_in);
      {first_reload_wr_in, second_reload_wr_in} = 2'b00;
      repeat (3) @(negedge clock_in);
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (raw_irq_status_out[IRQ_CD] !== 1'b1) begin
         @(negedge clock_in);
         n++;
         if (n > 3000) begin
            miscompares++;
            conclude();
         end
      end
   endtask
   task clear_irq;
      countdown_irq_clear_in = 1'b1;
      @(negedge clock_in);
      countdown_irq_clear_in = 1'b0;
      repeat (3) @(negedge clock_in);
      chk(32'(raw_irq_status_out), 32'h0000_0000);
   endtask
   initial begin
      int idx, len;
      logic [CNT_W-1:0] r1, r2, held;
      logic [PAT_W-1:0] pat;
      void'($urandom(31));
      repeat (12) @(negedge clock_in);
      rstn_in = 1'b1;
      @(negedge clock_in);
      chk(count_out, COUNT_RESET);
      chk(timer_control_out, CTRL_RESET);
      chk(32'(raw_irq_status_out), 32'h0000_0000);
      r1 = 32'(3 + $urandom % 4);
      r2 = r1 + 32'h0000_0002;
      reload(0, r1);
      reload(1, r2);
      chk(first_reload_value_out, r1);
      chk(second_reload_value_out, r2);
      for (int w = 0; w < PAT_WORDS; w++) begin
         pattern_data_in = $urandom;
         pat[w*WORD_W +: WORD_W] = pattern_data_in;
         pattern_wr_in = PAT_WORDS'(1 << w);
         @(negedge clock_in);
         pattern_wr_in = '0;
      end
      len = 5 + $urandom % 4;
      ctrl(WORD_W'(len << CTRL_PLEN_LSB) | 32'h0000_0001);
      // Read back the pattern while the counter runs
      for (int w = 0; w < PAT_WORDS; w++) begin
         chk(pattern_out[w*WORD_W +: WORD_W], pat[w*WORD_W +: WORD_W]);
      end
      idx = 0;
      repeat (2 * len) begin
         wait_irq();
         chk(count_out, pat[idx] ? r2 : r1);
         idx = (idx + 1 >= len) ? 0 : idx + 1;
         chk(32'(pattern_index_out), 32'(idx));
         clear_irq();
      end
      reload(0, r1 + 32'h0000_0007);
      chk(first_reload_value_out, r1);
      low_power_in = 1'b1;
      repeat (8) @(negedge clock_in);
      held = count_out;
      repeat (100) @(negedge clock_in);
      chk(count_out, held);
      low_power_in = 1'b0;
      ctrl(32'h0000_0000);
      chk(32'(timer_run_enable_out), 32'h0000_0000);
      ctrl(32'h0000_0002);
      reload(0, 32'h0000_0004);
      chk(32'(timer_run_enable_out), 32'h0000_0001);
      wait_irq();
      chk(count_out, COUNT_ZERO);
      clear_irq();
      repeat (150) @(negedge clock_in);
      chk(32'(raw_irq_status_out), 32'h0000_0000);
      ctrl(32'h0000_0003);
      wait_irq();
      chk(32'(timer_run_enable_out), 32'h0000_0000);
      clear_irq();
      ctrl(32'h0000_0004);
      reload(1, 32'h0000_0006);
      chk(32'(timer_run_enable_out), 32'h0000_0001);
      ctrl(32'h0000_0000);
      clear_irq();
      repeat (6) begin
         irq_mask_reg_in = IRQ_W'($urandom);
         calendar_irq_in = 1'($urandom);
         repeat (4) @(negedge clock_in);
         chk(32'(raw_irq_status_out), 32'({calendar_irq_in, 1'b0}));
         chk(32'(masked_irq_status_out), 32'({calendar_irq_in & irq_mask_reg_in[IRQ_CAL], 1'b0}));
         chk(32'(combined_irq_out), 32'(calendar_irq_in & irq_mask_reg_in[IRQ_CAL]));
      end
      conclude();
   end
endmodule
bind low_speed_countdown_timer lsc_timer_props props (.clock_in, .rstn_in, .low_power_in,
   .first_reload_wr_in, .irq_mask_reg_in, .countdown_irq_clear_in, .timer_control_out,
   .timer_run_enable_out, .count_out, .first_reload_value_out, .raw_irq_status_out,
   .masked_irq_status_out, .combined_irq_out);
